// ### src/pbmc_cfg.svh
/*
 * Timing constants for the power bank mode controller.
 * Assumes a 200 MHz controller clock; counts derive from times.
 */
`ifndef PBMC_CFG_SVH
`define PBMC_CFG_SVH

// --------------------------------------------------------------------
// Clock and time units
// --------------------------------------------------------------------
`define PBMC_CLK_MHZ          200
`define PBMC_TRAN_S           2
`define PBMC_HICCUP_S         2
`define PBMC_PB_BOOST_MS      100
`define PBMC_PB_BOOST_FL_MS   30
`define PBMC_PB_TORCH_S       3
`define PBMC_LIGHT_LOAD_S     45
`define PBMC_TORCH_MA         50
`define PBMC_PRE_PCT          10
`define PBMC_EOC_PCT          15
`define PBMC_RECHARGE_MV      200

// --------------------------------------------------------------------
// Derived cycle counts (64-bit products to avoid overflow)
// --------------------------------------------------------------------
`define PBMC_MS_CYC           (64'd1000 * `PBMC_CLK_MHZ)
`define PBMC_S_CYC            (64'd1000000 * `PBMC_CLK_MHZ)
`define PBMC_TRAN_CYC         (`PBMC_TRAN_S * `PBMC_S_CYC)
`define PBMC_HICCUP_CYC       (`PBMC_HICCUP_S * `PBMC_S_CYC)
`define PBMC_PB_BOOST_CYC     (`PBMC_PB_BOOST_MS * `PBMC_MS_CYC)
`define PBMC_PB_BOOST_FL_CYC  (`PBMC_PB_BOOST_FL_MS * `PBMC_MS_CYC)
`define PBMC_PB_TORCH_CYC     (`PBMC_PB_TORCH_S * `PBMC_S_CYC)
`define PBMC_LIGHT_LOAD_CYC   (`PBMC_LIGHT_LOAD_S * `PBMC_S_CYC)

`endif

// ### src/pbmc_pkg.sv
/*
 * Types shared by the power bank mode controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package pbmc_pkg;
   // -----------------------------------------------------------------
   // Modes and charger states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {PBMC_HIZ, PBMC_CHARGE, PBMC_BOOST} pbmc_mode_e;
   typedef enum logic [2:0] {PBMC_PRECOND, PBMC_FAST, PBMC_TOPOFF,
                             PBMC_EOC, PBMC_IDLE} pbmc_chg_e;

   // Synchronised comparator and pin inputs.
   typedef struct packed {
      logic input_supply;     // Input supply valid.
      logic standby_select;   // High selects high-impedance mode.
      logic push_button;      // Active high button level.
      logic bat_above_pre;    // Battery above precondition threshold.
      logic bat_at_term;      // Battery at termination voltage.
      logic cur_below_eoc;    // Charge current below end-of-charge level.
      logic bat_recharge;     // Battery fell below recharge level.
      logic out_uv;           // Output undervoltage during current limit.
      logic light_load;       // Output current below light-load threshold.
   } pbmc_in_s;

   // Power switch and charger drive.
   typedef struct packed {
      logic input_pass_switch;      // Input pass switch on.
      logic reverse_block;          // Block reverse current to input.
      logic converter_high_switch;  // Converter high-side enable.
      logic converter_low_switch;   // Converter low-side enable.
      logic buck_mode;              // Converter runs as buck.
      logic cv_mode;                // Constant-voltage regulation.
      logic [6:0] charge_pct;       // Requested charge current percent.
   } pbmc_drv_s;
endpackage
`default_nettype wire

// ### src/pbmc_sync.sv
/*
 * Two-flop synchroniser bank for the controller's slow inputs.
 * Assumes inputs are static relative to the clock for two cycles.
 */
`default_nettype none
module pbmc_sync #(
   parameter int W = 9
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   logic [W-1:0] meta_q;  // First stage, read only by the second.

   // ------------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------------
   // Reset value leaves the button released (bit 6 is the button).
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ### src/pbmc_top.sv
/*
 * Power bank mode controller: mode selection, push button qualifying,
 * torch toggling, input hiccup, light-load shutoff and charger states.
 * Assumes comparator inputs are clean logic levels; all timing comes
 * from the 200 MHz clock.
 */
// Operation
// - Valid input supply forces charge mode.
// - No input: low selects boost, high HiZ.
// - Boost/charge changes pass 2 s HiZ.
// - Plain variant: button held 100 ms enables boost.
// - Torch variant: button held 30 ms enables boost.
// - Torch off: 3 s press turns torch on.
// - Torch on: 3 s press turns torch off.
// - Output undervoltage: pass switch off, retry 2 s.
// - Charge: pass switch on, buck converter.
// - Boost: pass off, reverse block, boost converter.
// - HiZ: all power switches off.
// - Charge starts precondition until above threshold.
// - Precondition requests 10 percent current.
// - Above threshold: constant current fast charge.
// - Fast charge until termination, then top-off.
// - Top-off CV; below 15 percent ends charge.
// - End of charge stops, keeps watching battery.
// - 200 mV drop restarts constant current.
// - Boost light load for 45 s shuts off.
`include "pbmc_cfg.svh"
`default_nettype none
module pbmc_top
   import pbmc_pkg::*;
#(
   parameter bit          FLASHLIGHT  = 1'b0,
   parameter longint      TRAN_CYC    = `PBMC_TRAN_CYC,
   parameter longint      HICCUP_CYC  = `PBMC_HICCUP_CYC,
   parameter longint      PB_BOOST_CYC = (FLASHLIGHT ? `PBMC_PB_BOOST_FL_CYC
                                                     : `PBMC_PB_BOOST_CYC),
   parameter longint      PB_TORCH_CYC = `PBMC_PB_TORCH_CYC,
   parameter longint      LIGHT_CYC   = `PBMC_LIGHT_LOAD_CYC
) (
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire logic      input_supply,
   input  wire logic      standby_select,
   input  wire logic      push_button_n,
   input  wire logic      bat_above_pre,
   input  wire logic      bat_at_term,
   input  wire logic      cur_below_eoc,
   input  wire logic      bat_recharge,
   input  wire logic      out_uv,
   input  wire logic      light_load,
   output var  pbmc_drv_s drv,
   output var  logic      torch_driver_output,
   output var  logic [1:0] mode,
   output var  logic [2:0] chg_state
);
   localparam int CW = 40;  // Wide enough for every count at 200 MHz.

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (TRAN_CYC < 1 || HICCUP_CYC < 1 || PB_BOOST_CYC < 1 ||
       PB_TORCH_CYC < 1 || LIGHT_CYC < 1 || LIGHT_CYC >= (64'd1 << CW)) begin : g_chk
      $error("pbmc_top: timing counts out of range");
   end

   // ------------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------------
   pbmc_in_s raw;   // Raw pins, button inverted so zero means released.
   pbmc_in_s in_s;  // Synchronised copies.

   always_comb begin
      raw                = '0;
      raw.input_supply   = input_supply;
      raw.standby_select = standby_select;
      raw.push_button    = ~push_button_n;
      raw.bat_above_pre  = bat_above_pre;
      raw.bat_at_term    = bat_at_term;
      raw.cur_below_eoc  = cur_below_eoc;
      raw.bat_recharge   = bat_recharge;
      raw.out_uv         = out_uv;
      raw.light_load     = light_load;
   end

   pbmc_sync #(.W($bits(pbmc_in_s))) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .din    (raw),
      .dout   (in_s)
   );

   // Saturating-compare helper used by every timer.
   function automatic logic reached(input logic [CW-1:0] cnt, input longint lim);
      reached = (longint'(cnt) >= lim);
   endfunction

   // ------------------------------------------------------------------
   // Push button hold timer
   // ------------------------------------------------------------------
   // Counts while the button is held; holds its value one count past the torch limit
   // so a long press is seen exactly once per press.
   logic [CW-1:0] pb_cnt_q;
   logic          pb_boost_fire;   // Held past boost threshold this cycle.
   logic          pb_torch_fire;   // Held past torch threshold this cycle.

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pb_cnt_q <= '0;
      end else if (!in_s.push_button) begin
         pb_cnt_q <= '0;
      end else if (!reached(pb_cnt_q, PB_TORCH_CYC + 1)) begin
         pb_cnt_q <= pb_cnt_q + 1'b1;
      end
   end

   // Threshold is "more than", so fire one count past the figure.
   assign pb_boost_fire = in_s.push_button &&
                          (longint'(pb_cnt_q) == PB_BOOST_CYC);
   assign pb_torch_fire = in_s.push_button &&
                          (longint'(pb_cnt_q) == PB_TORCH_CYC);

   // ------------------------------------------------------------------
   // Torch driver
   // ------------------------------------------------------------------
   // Only flashlight builds toggle; others leave the driver off.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         torch_driver_output <= 1'b0;
      end else if (FLASHLIGHT && pb_torch_fire) begin
         torch_driver_output <= ~torch_driver_output;
      end
   end

   // ------------------------------------------------------------------
   // Mode selection with transition dwell
   // ------------------------------------------------------------------
   pbmc_mode_e mode_q;       // Current operating mode.
   pbmc_mode_e last_act_q;   // Last active mode, or the target of a HiZ dwell.
   logic       boost_req_q;  // Boost armed by a qualified button press.
   logic [CW-1:0] dwell_q;   // HiZ dwell counter.
   logic       dwell_busy_q; // Dwell in progress.
   logic       light_off;    // Light-load timeout this cycle.
   pbmc_mode_e want;         // Requested mode from the pins.

   // Pin decode; boost also needs a qualified press and no shutoff.
   always_comb begin
      if (in_s.input_supply) begin
         want = PBMC_CHARGE;
      end else if (!in_s.standby_select && boost_req_q) begin
         want = PBMC_BOOST;
      end else begin
         want = PBMC_HIZ;
      end
   end

   // Boost arming: set by a qualified press, cleared by a light-load
   // timeout, a HiZ request or a valid input supply.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         boost_req_q <= 1'b0;
      end else if (in_s.input_supply || in_s.standby_select) begin
         boost_req_q <= 1'b0;
      end else if (pb_boost_fire) begin
         boost_req_q <= 1'b1;
      end else if (light_off) begin
         boost_req_q <= 1'b0;
      end
   end

   // Mode machine. A change between the two active modes parks in HiZ
   // for the dwell time; entry from idle HiZ is immediate unless the last active mode was the other one.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mode_q       <= PBMC_HIZ;
         last_act_q   <= PBMC_HIZ;
         dwell_q      <= '0;
         dwell_busy_q <= 1'b0;
      end else begin
         unique case (mode_q)
            PBMC_HIZ: begin
               if (dwell_busy_q) begin
                  if (reached(dwell_q, TRAN_CYC - 1)) begin
                     dwell_busy_q <= 1'b0;
                     dwell_q      <= '0;
                  end else begin
                     dwell_q <= dwell_q + 1'b1;
                  end
               end else if (want != PBMC_HIZ) begin
                  if (last_act_q != PBMC_HIZ && last_act_q != want) begin
                     dwell_busy_q <= 1'b1;
                     last_act_q   <= want;
                  end else begin
                     mode_q     <= want;
                     last_act_q <= want;
                  end
               end
            end
            PBMC_CHARGE, PBMC_BOOST: begin
               if (want != mode_q) begin
                  mode_q <= PBMC_HIZ;
                  if (want != PBMC_HIZ) begin
                     dwell_busy_q <= 1'b1;
                     last_act_q   <= want;
                  end
               end
            end
            default: begin
               mode_q <= PBMC_HIZ;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Light-load timer in boost
   // ------------------------------------------------------------------
   logic [CW-1:0] light_cnt_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         light_cnt_q <= '0;
      end else if (mode_q != PBMC_BOOST || !in_s.light_load) begin
         light_cnt_q <= '0;
      end else if (!reached(light_cnt_q, LIGHT_CYC)) begin
         light_cnt_q <= light_cnt_q + 1'b1;
      end
   end

   assign light_off = (mode_q == PBMC_BOOST) &&
                      (longint'(light_cnt_q) == LIGHT_CYC - 1);

   // ------------------------------------------------------------------
   // Input pass switch hiccup
   // ------------------------------------------------------------------
   // Undervoltage while in charge mode turns the pass switch off for
   // the retry time; a retry with the fault still present re-trips.
   logic          hiccup_q;
   logic [CW-1:0] hic_cnt_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hiccup_q  <= 1'b0;
         hic_cnt_q <= '0;
      end else if (hiccup_q) begin
         if (reached(hic_cnt_q, HICCUP_CYC - 1)) begin
            hiccup_q  <= 1'b0;
            hic_cnt_q <= '0;
         end else begin
            hic_cnt_q <= hic_cnt_q + 1'b1;
         end
      end else if (mode_q == PBMC_CHARGE && in_s.out_uv) begin
         hiccup_q <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Battery charger states
   // ------------------------------------------------------------------
   pbmc_chg_e chg_q;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chg_q <= PBMC_IDLE;
      end else if (mode_q != PBMC_CHARGE) begin
         chg_q <= PBMC_IDLE;
      end else begin
         unique case (chg_q)
            PBMC_IDLE: begin
               chg_q <= PBMC_PRECOND;
            end
            PBMC_PRECOND: begin
               if (in_s.bat_above_pre) chg_q <= PBMC_FAST;
            end
            PBMC_FAST: begin
               if (in_s.bat_at_term) chg_q <= PBMC_TOPOFF;
            end
            PBMC_TOPOFF: begin
               if (in_s.cur_below_eoc) chg_q <= PBMC_EOC;
            end
            PBMC_EOC: begin
               if (in_s.bat_recharge) chg_q <= PBMC_FAST;
            end
            default: begin
               chg_q <= PBMC_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Output drive, registered
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drv       <= '0;
         mode      <= 2'h0;
         chg_state <= 3'h0;
      end else begin
         drv       <= '0;
         mode      <= mode_q;
         chg_state <= chg_q;
         unique case (mode_q)
            PBMC_CHARGE: begin
               drv.input_pass_switch <= ~hiccup_q;
               drv.buck_mode         <= 1'b1;
               if (chg_q != PBMC_EOC && chg_q != PBMC_IDLE) begin
                  drv.converter_high_switch <= 1'b1;
                  drv.converter_low_switch  <= 1'b1;
               end
               drv.cv_mode <= (chg_q == PBMC_TOPOFF);
               if (chg_q == PBMC_PRECOND) begin
                  drv.charge_pct <= 7'(`PBMC_PRE_PCT);
               end else if (chg_q == PBMC_FAST || chg_q == PBMC_TOPOFF) begin
                  drv.charge_pct <= 7'd100;
               end
            end
            PBMC_BOOST: begin
               drv.reverse_block         <= 1'b1;
               drv.converter_high_switch <= 1'b1;
               drv.converter_low_switch  <= 1'b1;
            end
            PBMC_HIZ: begin
               drv <= '0;
            end
            default: begin
               drv <= '0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### verif/pbmc_batt_model.sv
/*
 * Cell and comparator model facing the controller.
 * Assumes drive levels change on the rising clock edge.
 */
`default_nettype none
module pbmc_batt_model
   import pbmc_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      resetn,
   input  wire pbmc_drv_s drv,
   input  wire logic      drain,
   output var  logic      bat_above_pre,
   output var  logic      bat_at_term,
   output var  logic      cur_below_eoc,
   output var  logic      bat_recharge
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------
   // Cell charge state
   // ----------
   logic [5:0] lvl_q;  // Cell charge in arbitrary steps.
   logic [2:0] sub_q;  // Divides the trickle rate by eight.
   logic [3:0] cv_q;   // Cycles spent under constant voltage.
   logic       chg;    // The cell receives current this cycle.

   assign chg = drv.input_pass_switch && drv.buck_mode;

   // The slow trickle keeps precondition long enough to be watched.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lvl_q <= 6'h00;
         sub_q <= 3'h0;
      end else if (drain) begin
         lvl_q <= lvl_q - 6'h08;
      end else if (chg && lvl_q < 6'h1e) begin
         sub_q <= sub_q + 3'h1;
         if (drv.charge_pct == 7'h64 || (drv.charge_pct == 7'h0a && sub_q == 3'h7)) begin
            lvl_q <= lvl_q + 6'h01;
         end
      end
   end

   // Taper ends after eight cycles of regulation.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cv_q <= 4'h0;
      end else if (!drv.cv_mode) begin
         cv_q <= 4'h0;
      end else if (cv_q != 4'hf) begin
         cv_q <= cv_q + 4'h1;
      end
   end

   assign bat_above_pre = (lvl_q >= 6'h0a);  // Precondition threshold.
   assign bat_at_term   = (lvl_q >= 6'h1e);  // Termination voltage.
   assign cur_below_eoc = (cv_q >= 4'h8);    // Taper below end level.
   assign bat_recharge  = (lvl_q <= 6'h18);  // Well below full charge.
endmodule
`default_nettype wire

// ### verif/pbmc_top_chk.sv
/*
 * Port assertions for the mode controller.
 * Assumes binding to pbmc_top, sharing its counts.
 */
`default_nettype none
module pbmc_top_chk
   import pbmc_pkg::*;
#(
   parameter longint TRAN_CYC     = 20,
   parameter longint PB_TORCH_CYC = 30
) (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       input_supply,
   input wire logic       out_uv,
   input wire logic       push_button_n,
   input wire pbmc_drv_s  drv,
   input wire logic       torch_driver_output,
   input wire logic [1:0] mode,
   input wire logic [2:0] chg_state
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------
   // Helper counters
   // ----------
   logic [1:0]  last_act_q;   // Last active mode.
   logic [31:0] hiz_cnt_q;    // HiZ run length.
   logic [31:0] sup_cnt_q;    // Supply run length.
   logic [31:0] press_cnt_q;  // Latest press length.
   logic        pb_prev_q;    // Button level one cycle back.

   // Run-length helpers.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         last_act_q  <= PBMC_HIZ;
         hiz_cnt_q   <= '0;
         sup_cnt_q   <= '0;
         press_cnt_q <= '0;
         pb_prev_q   <= 1'b1;
      end else begin
         last_act_q  <= (mode != PBMC_HIZ) ? mode : last_act_q;
         hiz_cnt_q   <= (mode == PBMC_HIZ) ? hiz_cnt_q + 1 : '0;
         sup_cnt_q   <= !input_supply ? '0 : sup_cnt_q + (sup_cnt_q < 1000);
         pb_prev_q   <= push_button_n;
         if (!push_button_n) begin
            press_cnt_q <= pb_prev_q ? 32'h1 : press_cnt_q + 1;
         end
      end
   end
   // ----------
   // Assertions
   // ----------
   property p_hiz_off;
      (mode == PBMC_HIZ)[*2] |-> !drv.input_pass_switch && !drv.converter_high_switch
                                 && !drv.converter_low_switch;
   endproperty
   a_hiz_off: assert property (p_hiz_off) else $error("switch on in high impedance");
   property p_fast_drv;
      (mode == PBMC_CHARGE && chg_state == PBMC_FAST)[*3] |-> drv.buck_mode
         && drv.converter_high_switch && drv.charge_pct == 7'h64 && !drv.cv_mode;
   endproperty
   a_fast_drv: assert property (p_fast_drv) else $error("bad fast charge drive");
   property p_pre_pct;
      (mode == PBMC_CHARGE && chg_state == PBMC_PRECOND)[*3] |-> drv.charge_pct == 7'h0a;
   endproperty
   a_pre_pct: assert property (p_pre_pct) else $error("bad precondition current");
   property p_topoff_cv;
      (mode == PBMC_CHARGE && chg_state == PBMC_TOPOFF)[*3] |-> drv.cv_mode;
   endproperty
   a_topoff_cv: assert property (p_topoff_cv) else $error("top-off not in cv");
   property p_eoc_stop;
      (chg_state == PBMC_EOC)[*3] |-> drv.charge_pct == 7'h00;
   endproperty
   a_eoc_stop: assert property (p_eoc_stop) else $error("charging after end");
   property p_boost_drv;
      (mode == PBMC_BOOST)[*2] |-> !drv.input_pass_switch && drv.reverse_block
                                   && !drv.buck_mode && drv.converter_low_switch
                                   && drv.converter_high_switch;
   endproperty
   a_boost_drv: assert property (p_boost_drv) else $error("bad boost drive");
   property p_tran;
      (mode != PBMC_HIZ && $past(mode) == PBMC_HIZ && last_act_q != PBMC_HIZ
         && last_act_q != mode) |-> hiz_cnt_q >= TRAN_CYC - 1;
   endproperty
   a_tran: assert property (p_tran) else $error("dwell skipped");
   property p_supply;
      sup_cnt_q == TRAN_CYC + 12 |-> mode == PBMC_CHARGE;
   endproperty
   a_supply: assert property (p_supply) else $error("valid supply not charging");
   property p_torch;
      $changed(torch_driver_output) |-> press_cnt_q >= PB_TORCH_CYC;
   endproperty
   a_torch: assert property (p_torch) else $error("torch toggled on short press");
   property p_hiccup;
      ($rose(out_uv) && mode == PBMC_CHARGE ##1 mode == PBMC_CHARGE)
         |-> ##[1:8] !drv.input_pass_switch;
   endproperty
   a_hiccup: assert property (p_hiccup) else $error("pass switch kept on");
endmodule

bind pbmc_top pbmc_top_chk #(.TRAN_CYC(TRAN_CYC), .PB_TORCH_CYC(PB_TORCH_CYC)) pbmc_top_chk_inst (
   .clk, .resetn, .input_supply, .out_uv, .push_button_n, .drv, .torch_driver_output,
   .mode, .chg_state
);
`default_nettype wire

// ### verif/pbmc_tb_top.sv
/*
 * Self-checking bench for the power bank mode controller.
 * Assumes the bound checker and the cell model; counts are shortened.
 */
`default_nettype none
module pbmc_tb_top
   import pbmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // Shortened transition, hiccup, press, torch and light-load counts.
   localparam int TRAN = 20;
   localparam int HIC  = 20;
   localparam int PBB  = 5;
   localparam int PBT  = 30;
   localparam int LIT  = 40;

   logic       clk, resetn, input_supply, standby_select, push_button_n;
   logic       bat_above_pre, bat_at_term, cur_below_eoc, bat_recharge;
   logic       out_uv, light_load, drain, torch_driver_output;
   logic [1:0] mode;
   logic [2:0] chg_state;
   pbmc_drv_s  drv;
   int         fails;      // Mismatches seen.
   int         tests_run;  // Comparisons made.
   int         n;          // Last wait length.

   pbmc_top #(.FLASHLIGHT(1'b1), .TRAN_CYC(TRAN), .HICCUP_CYC(HIC), .PB_BOOST_CYC(PBB),
              .PB_TORCH_CYC(PBT), .LIGHT_CYC(LIT)) pbmc_top_inst (
      .clk, .resetn, .input_supply, .standby_select, .push_button_n, .bat_above_pre,
      .bat_at_term, .cur_below_eoc, .bat_recharge, .out_uv, .light_load, .drv,
      .torch_driver_output, .mode, .chg_state);
   pbmc_batt_model pbmc_batt_model_inst (
      .clk, .resetn, .drv, .drain, .bat_above_pre, .bat_at_term, .cur_below_eoc,
      .bat_recharge);

   // 200 MHz clock.
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   // ----------
   // Shared tasks
   // ----------
   task automatic give_verdict();
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // Inputs move 1 ns after the edge.
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic press(input int k);
      push_button_n = 1'b0;
      tick(k);
      push_button_n = 1'b1;
      tick(1);
   endtask

   function automatic logic [2:0] probe(input int sel);
      case (sel)
         0: return {1'b0, mode};
         1: return chg_state;
         default: return {2'b00, drv.input_pass_switch};
      endcase
   endfunction

   // A wait that runs out ends the run failed.
   task automatic wait_for(input int sel, input logic [2:0] val, input int lim, output int k);
      k = 0;
      while (probe(sel) !== val) begin
         tick(1);
         k++;
         if (k > lim) begin
            fails++;
            $display("MISMATCH wait_%0d expected %0h seen %0h", sel, val, probe(sel));
            give_verdict();
         end
      end
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic sc_charge();
      check("rst_mode", 32'(mode), 32'(PBMC_HIZ));
      check("rst_drv", 32'(drv), 32'h0);
      check("rst_chg", 32'(chg_state), 32'(PBMC_IDLE));
      input_supply = 1'b1;
      wait_for(0, 3'(PBMC_CHARGE), 10, n);
      tick(3);
      check("pass", 32'(drv.input_pass_switch), 32'h1);
      check("buck", 32'(drv.buck_mode), 32'h1);
      check("pre", 32'(chg_state), 32'(PBMC_PRECOND));
      check("pre_pct", 32'(drv.charge_pct), 32'h0a);
      wait_for(1, 3'(PBMC_FAST), 120, n);
      tick(3);
      check("fast_pct", 32'(drv.charge_pct), 32'h64);
      wait_for(1, 3'(PBMC_TOPOFF), 60, n);
      tick(3);
      check("top_cv", 32'(drv.cv_mode), 32'h1);
      wait_for(1, 3'(PBMC_EOC), 40, n);
      tick(3);
      check("eoc_pct", 32'(drv.charge_pct), 32'h0);
      drain = 1'b1;
      tick(1);
      drain = 1'b0;
      wait_for(1, 3'(PBMC_FAST), 10, n);
   endtask

   task automatic sc_hiccup();
      out_uv = 1'b1;
      tick(2);
      out_uv = 1'b0;
      wait_for(2, 3'h0, 8, n);
      wait_for(2, 3'h1, HIC + 8, n);
      check("hic_len", 32'(n >= HIC - 2), 32'h1);
   endtask

   task automatic sc_boost();
      input_supply = 1'b0;
      press(PBB + 4);
      wait_for(0, 3'(PBMC_BOOST), TRAN + 12, n);
      check("tran_len", 32'(n + PBB + 5 >= TRAN), 32'h1);
      tick(2);
      check("b_pass", 32'(drv.input_pass_switch), 32'h0);
      check("b_rev", 32'(drv.reverse_block), 32'h1);
      check("b_buck", 32'(drv.buck_mode), 32'h0);
      light_load = 1'b1;
      wait_for(0, 3'(PBMC_HIZ), LIT + 12, n);
      check("light_len", 32'(n >= LIT - 1), 32'h1);
      light_load = 1'b0;
   endtask

   task automatic sc_refuse();
      press(PBB - 2);
      tick(TRAN + 8);
      check("short_press", 32'(mode), 32'(PBMC_HIZ));
      standby_select = 1'b1;
      press(PBB + 4);
      tick(8);
      check("standby_mode", 32'(mode), 32'(PBMC_HIZ));
      check("standby_drv", 32'({drv.input_pass_switch, drv.converter_high_switch,
                                drv.converter_low_switch}), 32'h0);
   endtask

   task automatic sc_torch();
      press(PBT - 5);
      tick(4);
      check("torch_short", 32'(torch_driver_output), 32'h0);
      press(PBT + 5);
      tick(4);
      check("torch_on", 32'(torch_driver_output), 32'h1);
      press(PBT + 5);
      tick(4);
      check("torch_off", 32'(torch_driver_output), 32'h0);
      input_supply = 1'b1;
      wait_for(0, 3'(PBMC_CHARGE), TRAN + 12, n);
   endtask
   // ----------
   // Main sequence
   // ----------
   initial begin
      fails = 0;
      tests_run = 0;
      resetn = 1'b0;
      input_supply = 1'b0;
      standby_select = 1'b0;
      push_button_n = 1'b1;
      out_uv = 1'b0;
      light_load = 1'b0;
      drain = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      resetn = 1'b1;
      tick(3);
      sc_charge();
      sc_hiccup();
      sc_boost();
      sc_refuse();
      sc_torch();
      give_verdict();
   end
endmodule
`default_nettype wire
